/* File: hdl/dsw_pkg.sv */
// Package with constants for the drive status word and reference scaling block.
// What this block does
// - Bit 00 set when controls ready, cleared on trip
// - Bit 01 set when ready despite coast command
// - Bit 02 low while coasting, high when enabled
// - Bit 03 set while tripped until reset
// - Bit 04 set on error without trip
// - Bit 05 unused, always zero
// - Bit 06 set when tripped and locked
// - Bit 07 set while any warning present
// - Bit 08 set when speed equals reference
// - Bit 09 set when bus may control drive
// - Bit 10 set while frequency within limits
// - Bit 11 set on start or nonzero frequency
// - Bit 12 set on overtemperature auto-restart halt
// - Bit 13 set when DC voltage out of range
// - Bit 14 set when current exceeds limit
// - Bit 15 set when thermal timer exceeds full
// - Whole word zero when link lost
// - Reference 16384 equals full scale, max 32767
// - Negative reference in two's complement
// - Actual output value uses same scaling
package dsw_pkg;
	localparam int           DSW_WORD_W      = 16;
	localparam int           DSW_FRAC_W      = 14;
	localparam logic [15:0]  DSW_FULL_SCALE  = 16'h4000;
	localparam logic [15:0]  DSW_POS_MAX     = 16'h7fff;
	localparam logic [15:0]  DSW_NEG_MIN     = 16'h8000;
	localparam logic [15:0]  DSW_WORD_RST    = 16'h0000;
	localparam int           DSW_B_CTRL_RDY  = 0;
	localparam int           DSW_B_DRV_RDY   = 1;
	localparam int           DSW_B_ENABLE    = 2;
	localparam int           DSW_B_TRIP      = 3;
	localparam int           DSW_B_ERROR     = 4;
	localparam int           DSW_B_UNUSED    = 5;
	localparam int           DSW_B_TRIP_LOCK = 6;
	localparam int           DSW_B_WARNING   = 7;
	localparam int           DSW_B_AT_REF    = 8;
	localparam int           DSW_B_BUS_CTRL  = 9;
	localparam int           DSW_B_FREQ_OK   = 10;
	localparam int           DSW_B_RUNNING   = 11;
	localparam int           DSW_B_OT_AUTO   = 12;
	localparam int           DSW_B_VOLT_EXC  = 13;
	localparam int           DSW_B_TORQ_EXC  = 14;
	localparam int           DSW_B_TIMER_EXC = 15;
endpackage : dsw_pkg

/* File: hdl/dsw_status.sv */
// Drive status word builder and relative speed scaling.
`timescale 1ns/1ps
module dsw_status
	import dsw_pkg::*;
#(
	parameter int FREQ_W = 16
)
(
	input  wire logic                    ref_clk,
	input  wire logic                    rst_n,
	input  wire logic                    ctrl_ready,
	input  wire logic                    drive_ready,
	input  wire logic                    coast_active,
	input  wire logic                    tripped,
	input  wire logic                    error_no_trip,
	input  wire logic                    trip_locked,
	input  wire logic                    warning_any,
	input  wire logic                    stop_reset_local,
	input  wire logic                    local_ref_sel,
	input  wire logic                    start_present,
	input  wire logic                    overtemp_halt,
	input  wire logic                    dc_volt_low,
	input  wire logic                    dc_volt_high,
	input  wire logic                    current_over_limit,
	input  wire logic                    thermal_timer_over,
	input  wire logic                    link_ok,
	input  wire logic [FREQ_W-1:0]       out_freq,
	input  wire logic [FREQ_W-1:0]       freq_low_limit,
	input  wire logic [FREQ_W-1:0]       freq_high_limit,
	input  wire logic [FREQ_W-1:0]       freq_full_scale,
	input  wire logic                    out_reverse,
	input  wire logic [DSW_WORD_W-1:0]   bus_speed_ref,
	output logic      [DSW_WORD_W-1:0]   drive_condition_word,
	output logic      [DSW_WORD_W-1:0]   actual_output_value,
	output logic      [DSW_WORD_W-1:0]   ref_target_freq,
	output logic                         ref_reverse
);
	logic [DSW_WORD_W-1:0]   word_d;
	logic [DSW_WORD_W-1:0]   ref_mag;
	logic [FREQ_W-1:0]       ref_freq;
	logic [FREQ_W-1:0]       tgt_freq_d;
	logic [DSW_WORD_W-1:0]   mav_mag;
	logic [DSW_WORD_W-1:0]   mav_d;
	logic [FREQ_W+15:0]      prod_ref;
	logic [FREQ_W+15:0]      prod_mav;
	logic [FREQ_W+15:0]      quot_mav;
	logic                    running;
	logic                    bus_ctrl;

	assign running  = start_present || (out_freq != '0);
	assign bus_ctrl = !(stop_reset_local || local_ref_sel);

	always_comb
	begin
		word_d                  = DSW_WORD_RST;
		word_d[DSW_B_CTRL_RDY]  = ctrl_ready && !tripped;
		word_d[DSW_B_DRV_RDY]   = drive_ready && coast_active;
		word_d[DSW_B_ENABLE]    = drive_ready && !coast_active;
		word_d[DSW_B_TRIP]      = tripped;
		word_d[DSW_B_ERROR]     = error_no_trip && !tripped;
		word_d[DSW_B_UNUSED]    = 1'b0;
		word_d[DSW_B_TRIP_LOCK] = tripped && trip_locked;
		word_d[DSW_B_WARNING]   = warning_any;
		word_d[DSW_B_AT_REF]    = (out_freq == tgt_freq_d);
		word_d[DSW_B_BUS_CTRL]  = bus_ctrl;
		word_d[DSW_B_FREQ_OK]   = (out_freq > freq_low_limit) &&
			(out_freq < freq_high_limit);
		word_d[DSW_B_RUNNING]   = running;
		word_d[DSW_B_OT_AUTO]   = overtemp_halt && !tripped;
		word_d[DSW_B_VOLT_EXC]  = dc_volt_low || dc_volt_high;
		word_d[DSW_B_TORQ_EXC]  = current_over_limit;
		word_d[DSW_B_TIMER_EXC] = thermal_timer_over;
		if (!link_ok)
		begin
			word_d = DSW_WORD_RST;
		end
	end

	// Magnitude of the signed reference; the most negative code saturates.
	always_comb
	begin
		if (bus_speed_ref[DSW_WORD_W-1])
		begin
			ref_mag = (bus_speed_ref == DSW_NEG_MIN) ? DSW_POS_MAX : (~bus_speed_ref + 16'h0001);
		end
		else
		begin
			ref_mag = bus_speed_ref;
		end
	end

	// Reference magnitude times full-scale frequency over 16384.
	assign prod_ref   = {{FREQ_W{1'b0}}, ref_mag} * {16'h0000, freq_full_scale};
	assign ref_freq   = FREQ_W'(prod_ref >> DSW_FRAC_W);
	assign tgt_freq_d = ref_freq;

	// Actual frequency expressed in the same relative scale, clamped.
	assign prod_mav = {16'h0000, out_freq} << DSW_FRAC_W;
	assign quot_mav = (freq_full_scale == '0) ? '0 :
		prod_mav / {16'h0000, freq_full_scale};

	always_comb
	begin
		if (quot_mav > {{FREQ_W{1'b0}}, DSW_POS_MAX})
		begin
			mav_mag = DSW_POS_MAX;
		end
		else
		begin
			mav_mag = quot_mav[DSW_WORD_W-1:0];
		end
		mav_d = out_reverse ? (~mav_mag + 16'h0001) : mav_mag;
	end

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			drive_condition_word <= DSW_WORD_RST;
		end
		else
		begin
			drive_condition_word <= word_d;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			actual_output_value <= DSW_WORD_RST;
		end
		else
		begin
			actual_output_value <= mav_d;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ref_target_freq <= '0;
			ref_reverse     <= 1'b0;
		end
		else
		begin
			ref_target_freq <= DSW_WORD_W'(tgt_freq_d);
			ref_reverse     <= bus_speed_ref[DSW_WORD_W-1];
		end
	end
endmodule : dsw_status

/* File: dv/dsw_status_props.sv */
// Checker for the status word and reference sign.
`timescale 1ns/1ps
module dsw_status_chk
(
	input wire logic        ref_clk,
	input wire logic        rst_n,
	input wire logic        ctrl_ready,
	input wire logic        drive_ready,
	input wire logic        coast_active,
	input wire logic        tripped,
	input wire logic        trip_locked,
	input wire logic        link_ok,
	input wire logic [15:0] bus_speed_ref,
	input wire logic [15:0] drive_condition_word,
	input wire logic        ref_reverse
);
	wire [15:0] w = drive_condition_word;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	sequence s_live;
		$past(rst_n) && $past(link_ok);
	endsequence
	a_link_zero: assert property ($past(rst_n) && !$past(link_ok) |-> w == 16'h0000)
		else $error("word not cleared");
	a_ready_bit: assert property (s_live |-> w[0] == ($past(ctrl_ready) && !$past(tripped)))
		else $error("ready bit");
	a_drive_ready: assert property (s_live |-> w[1] == ($past(drive_ready) && $past(coast_active)))
		else $error("drive ready bit");
	a_enable_bit: assert property (s_live |-> w[2] == ($past(drive_ready) && !$past(coast_active)))
		else $error("enable bit");
	a_trip_bit: assert property (s_live |-> w[3] == $past(tripped))
		else $error("trip bit");
	a_spare_zero: assert property (w[5] == 1'b0)
		else $error("spare bit");
	a_lock_bit: assert property (s_live |-> w[6] == ($past(tripped) && $past(trip_locked)))
		else $error("lock bit");
	a_ref_sign: assert property ($past(rst_n) |-> ref_reverse == $past(bus_speed_ref[15]))
		else $error("reverse flag");
endmodule : dsw_status_chk
bind dsw_status dsw_status_chk u_chk (.ref_clk(ref_clk), .rst_n(rst_n), .ctrl_ready(ctrl_ready),
	.drive_ready(drive_ready), .coast_active(coast_active), .tripped(tripped),
	.trip_locked(trip_locked), .link_ok(link_ok), .bus_speed_ref(bus_speed_ref),
	.drive_condition_word(drive_condition_word), .ref_reverse(ref_reverse));

/* File: dv/dsw_master_model.sv */
// Fieldbus master model that sends the relative speed reference.
`timescale 1ns/1ps
module dsw_master_model
(
	input  wire logic        ref_clk,
	output logic      [15:0] bus_speed_ref
);
	initial bus_speed_ref = 16'h0000;
	task automatic send(input logic [15:0] v);
		@(posedge ref_clk);
		bus_speed_ref <= v;
	endtask : send
endmodule : dsw_master_model

/* File: dv/dsw_status_bench.sv */
// Self-checking bench for the status word builder.
`timescale 1ns/1ps
module dsw_status_bench;
	logic        ref_clk, rst_n, link_ok, out_reverse, ref_reverse;
	logic        ctrl_ready, drive_ready, coast_active, tripped, error_no_trip, trip_locked;
	logic        warning_any, stop_reset_local, local_ref_sel, start_present, overtemp_halt;
	logic        dc_volt_low, dc_volt_high, current_over_limit, thermal_timer_over;
	logic [14:0] c;
	logic [15:0] out_freq, freq_low_limit, freq_high_limit, freq_full_scale, bus_speed_ref, m;
	logic [15:0] drive_condition_word, actual_output_value, ref_target_freq;
	int          mismatches, n_tests;
	assign {thermal_timer_over, current_over_limit, dc_volt_high, dc_volt_low, overtemp_halt,
		start_present, local_ref_sel, stop_reset_local, warning_any, trip_locked,
		error_no_trip, tripped, coast_active, drive_ready, ctrl_ready} = c;
	dsw_status dut (.*);
	dsw_master_model master (.ref_clk(ref_clk), .bus_speed_ref(bus_speed_ref));
	initial
	begin
		ref_clk = 0;
		forever #2.5 ref_clk = ~ref_clk;
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			mismatches++;
			$display("MISMATCH %0t %h %h", $time, got, exp);
		end
	endtask : chk
	function automatic logic [15:0] ew(input logic [14:0] v, input logic l);
		logic [15:0] x;
		x = {v[14], v[13], v[12] | v[11], v[10] & !v[3], v[9] | (out_freq != 0),
			(out_freq > freq_low_limit) && (out_freq < freq_high_limit), !(v[7] | v[8]),
			out_freq == m, v[6], v[5] & v[3], 1'b0, v[4] & !v[3], v[3], v[1] & !v[2],
			v[1] & v[2], v[0] & !v[3]};
		return l ? x : 16'h0000;
	endfunction : ew
	task automatic step(input logic [14:0] v, input logic l, input logic [15:0] r);
		master.send(r);
		c <= v;
		link_ok <= l;
		m = r[15] ? -r : r;
		if (m == 16'h8000)
			m = 16'h7fff;
		out_freq <= m;
		out_reverse <= r[15];
		@(posedge ref_clk);
		#1;
		chk(drive_condition_word, ew(v, l));
		chk(ref_target_freq, m);
		chk({15'h0000, ref_reverse}, {15'h0000, r[15]});
		chk(actual_output_value, (r == 16'h8000) ? 16'h8001 : r);
	endtask : step
	task automatic complete_run;
		$display("Checks %0d, mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : complete_run
	initial
	begin
		{rst_n, link_ok, c, out_reverse, out_freq, m, mismatches, n_tests} = '0;
		freq_low_limit = 16'h0100;
		freq_high_limit = 16'h7fff;
		freq_full_scale = 16'h4000;
		repeat (20) @(posedge ref_clk);
		chk(drive_condition_word, 16'h0000);
		rst_n <= 1;
		for (int i = 0; i < 15; i++)
			step(15'h0001 << i, 1'b1, 16'h4000);
		step(15'h7fff, 1'b1, 16'h7fff);
		step(15'h0006, 1'b1, 16'hc000);
		step(15'h0005, 1'b1, 16'h8000);
		step(15'h7fff, 1'b0, 16'h0000);
		step(15'h0209, 1'b1, 16'h0000);
		@(posedge ref_clk);
		out_freq <= 16'h0200;
		@(posedge ref_clk);
		#1;
		chk(drive_condition_word, ew(15'h0209, 1'b1));
		chk(actual_output_value, 16'h0200);
		complete_run;
	end
endmodule : dsw_status_bench
